/* hw/sdtc_pkg.sv */
package sdtc_pkg;

  localparam logic [7:0] OFF_TIMING   = 8'h50;
  localparam logic [7:0] OFF_ROWPOP   = 8'h52;
  localparam logic [7:0] OFF_UPPERPOP = 8'h54;
  localparam logic [7:0] OFF_HOLE     = 8'h58;
  localparam logic [7:0] OFF_MGMT_CTL = 8'h70;

  localparam logic [7:0] RST_TIMING   = 8'h00;
  localparam logic [7:0] RST_ROWPOP   = 8'h00;
  localparam logic [7:0] RST_UPPERPOP = 8'h00;
  localparam logic [7:0] RST_HOLE     = 8'h00;
  localparam logic [7:0] RST_MGMT_CTL = 8'h00;

  localparam int BIT_LAT    = 2;
  localparam int BIT_ACT    = 1;
  localparam int BIT_PRE    = 0;
  localparam int BIT_HOLE   = 7;
  localparam int BIT_LOCK   = 4;

  localparam logic [7:0] MASK_TIMING   = 8'h07;
  localparam logic [7:0] MASK_UPPERPOP = 8'h0f;
  localparam logic [7:0] MASK_HOLE     = 8'h80;
  localparam logic [7:0] MASK_MGMT_CTL = 8'h10;

  localparam logic [2:0] CYC_SLOW = 3'h3;
  localparam logic [2:0] CYC_FAST = 3'h2;

  localparam logic [28:0] HOLE_BASE = 29'h00f00000;
  localparam logic [28:0] HOLE_TOP  = 29'h01000000;
  localparam logic [29:0] MEM_LIMIT = 30'h20000000;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sdtc_cfg_t;

  typedef struct packed {
    logic [2:0] read_latency;
    logic [2:0] act_to_cmd;
    logic [2:0] precharge;
  } sdtc_timing_t;

  typedef enum logic [1:0] {
    SDTC_SRC_HOST = 2'b00,
    SDTC_SRC_HUB  = 2'b01,
    SDTC_SRC_PCI  = 2'b10
  } sdtc_src_t;

endpackage

/* hw/sdtc_timer.sv */
`timescale 1ns/100ps
module sdtc_timer (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       start,
  input  wire logic [2:0] count,
  output logic            done
);
  logic [2:0] cnt_r;

  // Pulses done exactly count - 1 clocks after start
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 3'h0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= count - 3'h1;
      end else if (cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
        done  <= (cnt_r == 3'h1);
      end
    end
  end
endmodule

/* hw/sdtc_decode.sv */
`timescale 1ns/100ps
module sdtc_decode (
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  input  wire logic                cyc_valid,
  input  wire sdtc_pkg::sdtc_src_t cyc_src,
  input  wire logic [31:0]         cyc_addr,
  input  wire logic                hole_en,
  input  wire logic [29:0]         mem_top,
  output logic                     to_dram,
  output logic                     to_hub,
  output logic                     claim
);
  logic in_hole;
  logic in_mem;

  assign in_hole = hole_en && cyc_addr[31:24] == 8'h00
                   && cyc_addr[28:0] >= sdtc_pkg::HOLE_BASE
                   && cyc_addr[28:0] < sdtc_pkg::HOLE_TOP;
  assign in_mem  = cyc_addr[31:30] == 2'b00 && cyc_addr[29:0] < mem_top;

  // Hole memory is not remapped; it is simply unreachable
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      to_dram <= 1'b0;
      to_hub  <= 1'b0;
      claim   <= 1'b0;
    end else begin
      to_dram <= cyc_valid && in_mem && !in_hole;
      if (cyc_src == sdtc_pkg::SDTC_SRC_HOST) begin
        to_hub <= cyc_valid && (in_hole || !in_mem);
        claim  <= cyc_valid;
      end else begin
        to_hub <= 1'b0;
        claim  <= cyc_valid && in_mem && !in_hole;
      end
    end
  end
endmodule

/* hw/sdtc_top.sv */
`timescale 1ns/100ps
module sdtc_top (
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  input  wire sdtc_pkg::sdtc_cfg_t cfg,
  output logic [7:0]               cfg_rdata,
  input  wire logic                act_cmd,
  input  wire logic                rd_cmd,
  input  wire logic                pre_cmd,
  output logic                     cmd_ok,
  output logic                     rdata_sample,
  output logic                     pre_done,
  output sdtc_pkg::sdtc_timing_t   timing,
  input  wire logic                cyc_valid,
  input  wire sdtc_pkg::sdtc_src_t cyc_src,
  input  wire logic [31:0]         cyc_addr,
  output logic                     to_dram,
  output logic                     to_hub,
  output logic                     claim,
  output logic [29:0]              mem_top
);
  logic [7:0]  timing_r;
  logic [7:0]  rowpop_r;
  logic [7:0]  upperpop_r;
  logic [7:0]  hole_r;
  logic [7:0]  mgmt_ctl_r;
  logic [7:0]  rdata_nxt;
  logic [2:0]  lat_cyc;
  logic [2:0]  act_cyc;
  logic [2:0]  pre_cyc;
  logic        act_done;
  logic        pre_done_w;
  logic        rd_done;
  logic        act_busy_r;
  logic [30:0] size_sum;
  logic        locked;

  function automatic logic [2:0] sel_cyc(input logic fast);
    sel_cyc = fast ? sdtc_pkg::CYC_FAST : sdtc_pkg::CYC_SLOW;
  endfunction

  // Population field to bytes, 64 MB units per side
  function automatic logic [30:0] side_bytes(input logic [1:0] code);
    side_bytes = {5'h00, code, 24'h000000} << 2;
  endfunction

  function automatic logic wr_hit(input sdtc_pkg::sdtc_cfg_t c, input logic [7:0] off);
    wr_hit = c.wr && c.addr == off;
  endfunction

  assign locked = mgmt_ctl_r[sdtc_pkg::BIT_LOCK];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timing_r <= sdtc_pkg::RST_TIMING;
    end else if (wr_hit(cfg, sdtc_pkg::OFF_TIMING)) begin
      timing_r <= cfg.wdata & sdtc_pkg::MASK_TIMING;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rowpop_r <= sdtc_pkg::RST_ROWPOP;
    end else if (wr_hit(cfg, sdtc_pkg::OFF_ROWPOP) && !locked) begin
      rowpop_r <= cfg.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      upperpop_r <= sdtc_pkg::RST_UPPERPOP;
    end else if (wr_hit(cfg, sdtc_pkg::OFF_UPPERPOP) && !locked) begin
      upperpop_r <= cfg.wdata & sdtc_pkg::MASK_UPPERPOP;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hole_r <= sdtc_pkg::RST_HOLE;
    end else if (wr_hit(cfg, sdtc_pkg::OFF_HOLE)) begin
      hole_r <= cfg.wdata & sdtc_pkg::MASK_HOLE;
    end
  end

  // Lock bit is write-once until reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mgmt_ctl_r <= sdtc_pkg::RST_MGMT_CTL;
    end else if (wr_hit(cfg, sdtc_pkg::OFF_MGMT_CTL)) begin
      mgmt_ctl_r <= mgmt_ctl_r | (cfg.wdata & sdtc_pkg::MASK_MGMT_CTL);
    end
  end

  always_comb begin
    unique case (cfg.addr)
      sdtc_pkg::OFF_TIMING:   rdata_nxt = timing_r;
      sdtc_pkg::OFF_ROWPOP:   rdata_nxt = rowpop_r;
      sdtc_pkg::OFF_UPPERPOP: rdata_nxt = upperpop_r;
      sdtc_pkg::OFF_HOLE:     rdata_nxt = hole_r;
      sdtc_pkg::OFF_MGMT_CTL: rdata_nxt = mgmt_ctl_r;
      default:                rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata <= 8'h00;
    end else if (cfg.rd) begin
      cfg_rdata <= rdata_nxt;
    end
  end

  assign lat_cyc = sel_cyc(timing_r[sdtc_pkg::BIT_LAT]);
  assign act_cyc = sel_cyc(timing_r[sdtc_pkg::BIT_ACT]);
  assign pre_cyc = sel_cyc(timing_r[sdtc_pkg::BIT_PRE]);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timing <= '0;
    end else begin
      timing <= '{read_latency: lat_cyc, act_to_cmd: act_cyc, precharge: pre_cyc};
    end
  end

  sdtc_timer u_lat (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .start   (rd_cmd),
    .count   (lat_cyc),
    .done    (rd_done)
  );

  sdtc_timer u_act (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .start   (act_cmd),
    .count   (act_cyc),
    .done    (act_done)
  );

  sdtc_timer u_pre (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .start   (pre_cmd),
    .count   (pre_cyc),
    .done    (pre_done_w)
  );

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      act_busy_r <= 1'b0;
    end else if (act_cmd) begin
      act_busy_r <= 1'b1;
    end else if (act_done) begin
      act_busy_r <= 1'b0;
    end
  end

  // Strobes out one clock after the internal done, counts include this flop
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ok       <= 1'b1;
      rdata_sample <= 1'b0;
      pre_done     <= 1'b0;
    end else begin
      cmd_ok       <= !(act_cmd || (act_busy_r && !act_done));
      rdata_sample <= rd_done;
      pre_done     <= pre_done_w;
    end
  end

  // Four 64-bit rows: two sides each of two DIMMs
  assign size_sum = side_bytes(rowpop_r[1:0]) + side_bytes(rowpop_r[5:4])
                  + side_bytes(upperpop_r[1:0]) + side_bytes(upperpop_r[3:2]);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mem_top <= 30'h00000000;
    end else if (size_sum > {1'b0, sdtc_pkg::MEM_LIMIT}) begin
      mem_top <= sdtc_pkg::MEM_LIMIT;
    end else begin
      mem_top <= size_sum[29:0];
    end
  end

  sdtc_decode u_dec (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .cyc_valid (cyc_valid),
    .cyc_src   (cyc_src),
    .cyc_addr  (cyc_addr),
    .hole_en   (hole_r[sdtc_pkg::BIT_HOLE]),
    .mem_top   (mem_top),
    .to_dram   (to_dram),
    .to_hub    (to_hub),
    .claim     (claim)
  );

  AST_LOCK_HOLDS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    locked |=> $stable(upperpop_r)) else $error("population changed while locked");

  AST_POP_RSVD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    upperpop_r[7:4] == 4'h0) else $error("population reserved bits set");

  AST_HOLE_RSVD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    hole_r[6:0] == 7'h00) else $error("hole reserved bits set");

  AST_MEM_LIMIT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mem_top <= sdtc_pkg::MEM_LIMIT) else $error("memory top above limit");

  AST_LAT_SLOW: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rd_cmd && !timing_r[sdtc_pkg::BIT_LAT] ##1 !rd_cmd [*3] |=> rdata_sample)
    else $error("slow read latency wrong");

  AST_PRE_FAST: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pre_cmd && timing_r[sdtc_pkg::BIT_PRE] ##1 !pre_cmd [*2] |=> pre_done)
    else $error("fast precharge wrong");

  AST_ACT_BLOCK: assert property (@(posedge clk_sys) disable iff (!reset_n)
    act_cmd |=> !cmd_ok) else $error("command allowed right after activate");

  AST_HOLE_HUB: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cyc_valid && cyc_src != sdtc_pkg::SDTC_SRC_HOST && hole_r[7]
    && cyc_addr[31:20] == 12'h00f |=> !claim) else $error("hole cycle claimed");

  AST_HOLE_HOST: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cyc_valid && cyc_src == sdtc_pkg::SDTC_SRC_HOST && hole_r[7]
    && cyc_addr[31:20] == 12'h00f |=> to_hub && !to_dram) else $error("hole not forwarded");

  AST_LAT_FAST: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rd_cmd && timing_r[sdtc_pkg::BIT_LAT] ##1 !rd_cmd [*2] |=> rdata_sample)
    else $error("fast read latency wrong");

  AST_PRE_SLOW: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pre_cmd && !timing_r[sdtc_pkg::BIT_PRE] ##1 !pre_cmd [*3] |=> pre_done)
    else $error("slow precharge wrong");

  AST_ACT_SLOW_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    act_cmd && !timing_r[sdtc_pkg::BIT_ACT] |=> !cmd_ok [*3])
    else $error("slow activate delay too short");

  AST_ACT_SLOW_OK: assert property (@(posedge clk_sys) disable iff (!reset_n)
    act_cmd && !timing_r[sdtc_pkg::BIT_ACT] ##1 !act_cmd [*3] |=> cmd_ok)
    else $error("slow activate delay too long");

  AST_ACT_FAST_OK: assert property (@(posedge clk_sys) disable iff (!reset_n)
    act_cmd && timing_r[sdtc_pkg::BIT_ACT] ##1 !act_cmd [*2] |=> cmd_ok)
    else $error("fast activate delay wrong");

  AST_RD_PULSE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rdata_sample |=> !rdata_sample)
    else $error("read sample strobe too long");

  AST_PRE_PULSE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pre_done |=> !pre_done)
    else $error("precharge strobe too long");

  AST_LOCK_STICKY: assert property (@(posedge clk_sys) disable iff (!reset_n)
    locked |=> locked)
    else $error("lock bit cleared");

  AST_HOLE_OFF_DRAM: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cyc_valid && !hole_r[sdtc_pkg::BIT_HOLE] && cyc_addr[31:20] == 12'h00f
    && cyc_addr[29:0] < mem_top |=> to_dram) else $error("closed hole range not sent to dram");

  AST_HOLE_NO_DRAM: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cyc_valid && hole_r[sdtc_pkg::BIT_HOLE] && cyc_addr[31:20] == 12'h00f |=> !to_dram)
    else $error("hole cycle reached dram");

  AST_HOST_CLAIM: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cyc_valid && cyc_src == sdtc_pkg::SDTC_SRC_HOST |=> claim)
    else $error("host cycle not claimed");

  AST_IDLE_QUIET: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !cyc_valid |=> !claim && !to_hub && !to_dram)
    else $error("routing output without a cycle");

  AST_HUB_NO_FWD: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cyc_valid && cyc_src != sdtc_pkg::SDTC_SRC_HOST |=> !to_hub)
    else $error("hub or pci cycle forwarded");

  AST_MEM_CAP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rowpop_r[1:0] == 2'h3 && rowpop_r[5:4] == 2'h3 && upperpop_r[3:2] == 2'h3
    |=> mem_top == sdtc_pkg::MEM_LIMIT) else $error("memory top not capped");
endmodule

/* tb/sdtc_dimm_model.sv */
`timescale 1ns/100ps
module sdtc_dimm_model (
  input  wire logic clk_sys,
  output logic      act_cmd,
  output logic      rd_cmd,
  output logic      pre_cmd
);
  initial begin
    act_cmd = 1'b0;
    rd_cmd  = 1'b0;
    pre_cmd = 1'b0;
  end
  // One command pulse, after an optional stall
  task automatic issue(input int kind, input int stall);
    repeat (stall) @(posedge clk_sys);
    @(posedge clk_sys);
    act_cmd <= (kind == 0);
    rd_cmd  <= (kind == 1);
    pre_cmd <= (kind == 2);
    @(posedge clk_sys);
    act_cmd <= 1'b0;
    rd_cmd  <= 1'b0;
    pre_cmd <= 1'b0;
  endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
  logic                   clk_sys;
  logic                   reset_n;
  sdtc_pkg::sdtc_cfg_t    cfg;
  logic [7:0]             cfg_rdata;
  logic                   act_cmd;
  logic                   rd_cmd;
  logic                   pre_cmd;
  logic                   cmd_ok;
  logic                   rdata_sample;
  logic                   pre_done;
  sdtc_pkg::sdtc_timing_t timing;
  logic                   cyc_valid;
  sdtc_pkg::sdtc_src_t    cyc_src;
  logic [31:0]            cyc_addr;
  logic                   to_dram;
  logic                   to_hub;
  logic                   claim;
  logic [29:0]            mem_top;
  int                     n_errors;
  int                     n_tests;
  int                     seed;
  logic [2:0]             c;
  logic [7:0]             d;
  logic [31:0]            a;
  logic [1:0]             s;
  logic                   h;

  sdtc_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .cfg(cfg), .cfg_rdata(cfg_rdata),
    .act_cmd(act_cmd), .rd_cmd(rd_cmd), .pre_cmd(pre_cmd), .cmd_ok(cmd_ok),
    .rdata_sample(rdata_sample), .pre_done(pre_done), .timing(timing),
    .cyc_valid(cyc_valid), .cyc_src(cyc_src), .cyc_addr(cyc_addr), .to_dram(to_dram),
    .to_hub(to_hub), .claim(claim), .mem_top(mem_top));

  sdtc_dimm_model dimm (.clk_sys(clk_sys), .act_cmd(act_cmd), .rd_cmd(rd_cmd),
    .pre_cmd(pre_cmd));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys; // 50 MHz, under the 100 MHz population limit
  end

  task end_sim;
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task cfg_wr(input logic [7:0] ad, input logic [7:0] wd);
    @(posedge clk_sys);
    cfg <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: wd};
    @(posedge clk_sys);
    cfg <= '0;
  endtask

  task cfg_rd(input logic [7:0] ad, input logic [7:0] e, input string nm);
    @(posedge clk_sys);
    cfg <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
    @(posedge clk_sys);
    cfg <= '0;
    #1;
    `CHK(nm, e, cfg_rdata)
  endtask

  // Cycles from the taken command edge to the answer
  task automatic t_meas(input int kind, input int stall, input logic [2:0] e, input string nm);
    int k;
    dimm.issue(kind, stall);
    k = 0;
    do begin
      @(posedge clk_sys);
      #1;
      k++;
    end while ((kind == 0 ? cmd_ok : kind == 1 ? rdata_sample : pre_done) !== 1'b1 && k < 10);
    `CHK(nm, e, k)
  endtask

  function automatic logic [2:0] exp_route(input logic [1:0] sr, input logic [31:0] ad,
                                           input logic he);
    logic inh;
    logic inm;
    inh = he && ad >= 32'h00f00000 && ad < 32'h01000000;
    inm = ad < 32'h18000000;
    exp_route = {inm && !inh, sr == 2'b00 && (inh || !inm), sr == 2'b00 || (inm && !inh)};
  endfunction

  initial begin
    #(20 * 5000);
    n_errors++;
    end_sim;
  end

  initial begin
    n_errors = 0;
    n_tests = 0;
    seed = 87;
    reset_n = 1'b0;
    cfg = '0;
    cyc_valid = 1'b0;
    cyc_src = sdtc_pkg::SDTC_SRC_HOST;
    cyc_addr = '0;
    h = 1'b1;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    cfg_rd(sdtc_pkg::OFF_UPPERPOP, 8'h00, "pop_rst");
    cfg_rd(sdtc_pkg::OFF_HOLE, 8'h00, "hole_rst");
    cfg_rd(8'h60, 8'h00, "unmapped");
    `CHK("timing_rst", 9'h0db, timing)
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      cfg_wr(sdtc_pkg::OFF_UPPERPOP, d);
      cfg_rd(sdtc_pkg::OFF_UPPERPOP, d & 8'h0f, "pop_rw");
      cfg_wr(sdtc_pkg::OFF_HOLE, d);
      cfg_rd(sdtc_pkg::OFF_HOLE, d & 8'h80, "hole_rw");
    end
    for (int b = 0; b < 2; b++) begin
      cfg_wr(sdtc_pkg::OFF_TIMING, b ? 8'h07 : 8'h00);
      c = b ? sdtc_pkg::CYC_FAST : sdtc_pkg::CYC_SLOW;
      @(posedge clk_sys);
      #1;
      `CHK("timing", {c, c, c}, timing)
      t_meas(0, b, c, "act_to_cmd");
      t_meas(1, 0, c, "rd_latency");
      t_meas(2, 2 * b, c, "precharge");
    end
    cfg_wr(sdtc_pkg::OFF_ROWPOP, 8'h33);
    cfg_wr(sdtc_pkg::OFF_UPPERPOP, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("mem_top", 30'h18000000, mem_top)
    `CHK("mem_cap", 1'b1, mem_top <= sdtc_pkg::MEM_LIMIT)
    for (int i = 0; i < 40; i++) begin
      if (i % 10 == 0) begin
        h = ~h;
        d = $random(seed);
        cfg_wr(sdtc_pkg::OFF_HOLE, {h, d[6:0]});
      end
      a = $random(seed);
      case (i % 5)
        0: a = {12'h00f, a[19:0]};
        1: a = 32'h00efffff;
        2: a = 32'h01000000;
        3: a = {4'h0, a[27:0]};
        default: ;
      endcase
      s = 2'({$random(seed)} % 3);
      @(posedge clk_sys);
      cyc_valid <= 1'b1;
      cyc_src   <= sdtc_pkg::sdtc_src_t'(s);
      cyc_addr  <= a;
      @(posedge clk_sys);
      cyc_valid <= 1'b0;
      #1;
      `CHK("route", exp_route(s, a, h), {to_dram, to_hub, claim})
    end
    cfg_wr(sdtc_pkg::OFF_UPPERPOP, 8'h0f);
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("mem_capped", sdtc_pkg::MEM_LIMIT, mem_top)
    cfg_wr(sdtc_pkg::OFF_UPPERPOP, 8'h05);
    cfg_wr(sdtc_pkg::OFF_MGMT_CTL, 8'h10);
    cfg_wr(sdtc_pkg::OFF_UPPERPOP, 8'h0a);
    cfg_rd(sdtc_pkg::OFF_UPPERPOP, 8'h05, "pop_lock");
    cfg_wr(sdtc_pkg::OFF_HOLE, 8'h00);
    cfg_rd(sdtc_pkg::OFF_HOLE, 8'h00, "hole_lock");
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    cfg_rd(sdtc_pkg::OFF_UPPERPOP, 8'h00, "pop_rst2");
    end_sim;
  end
endmodule
